// File: pkg/pmc_cfg.svh
// constants of the power mode controller
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// sleep level field encoding
`define PMC_LVL_W          2
`define PMC_LVL_RUN_IDLE   2'h0
`define PMC_LVL_LIGHT      2'h1
`define PMC_LVL_DEEP_TIMER 2'h2
`define PMC_LVL_DEEPEST    2'h3

// reset values
`define PMC_LVL_RESET      2'h0

// sysclk_source_select encoding
`define PMC_SRC_CRYSTAL    1'b0
// low_speed_osc_select encoding
`define PMC_LSO_SLOW_RC    1'b1

// sequence lengths in clk_sys cycles, and the width of the sequence counter
`define PMC_PD_FAST_CYC    4
`define PMC_PD_SLOW_CYC    16
`define PMC_PU_FAST_CYC    4
`define PMC_PU_SLOW_CYC    32
`define PMC_CNT_W          8

// default number of held i/o pins
`define PMC_IO_W           8

`endif

// File: pkg/pmc_pkg.sv
// types of the power mode controller
package pmc_pkg;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_IDLE,
    ST_PD,
    ST_LIGHT,
    ST_DEEP,
    ST_DEEPEST,
    ST_PU
  } pmc_state_type;

endpackage

// File: rtl/pmc_seq_timer.sv
// down counter timing power down and power up sequences
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_seq_timer #(
  parameter int CNT_W = `PMC_CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done_q
);
  logic [CNT_W-1:0] cnt_q;

  generate
    if (CNT_W < 2) begin : g_chk
      $error("pmc_seq_timer: CNT_W too small");
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // done pulses for one cycle, in the cycle after the count reaches one
  always_ff @(posedge clk_sys) begin
    if (reset || load) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// File: rtl/pmc_io_hold.sv
// freezes i/o direction and value while asleep
`timescale 1ns/1ps
module pmc_io_hold #(
  parameter int IO_W = 8
) (
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire logic            hold,
  input  wire logic [IO_W-1:0] io_dir_in,
  input  wire logic [IO_W-1:0] io_out_in,
  output logic      [IO_W-1:0] io_dir_q,
  output logic      [IO_W-1:0] io_out_q
);
  generate
    if (IO_W < 1) begin : g_chk
      $error("pmc_io_hold: IO_W must be positive");
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      io_dir_q <= '0;
      io_out_q <= '0;
    end else if (!hold) begin
      io_dir_q <= io_dir_in;
      io_out_q <= io_out_in;
    end
  end
endmodule

// File: rtl/pmc_ctrl.sv
// power mode controller: active, idle and three sleep states
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_ctrl #(
  parameter int IO_W        = `PMC_IO_W,
  parameter int PD_FAST_CYC = `PMC_PD_FAST_CYC,
  parameter int PD_SLOW_CYC = `PMC_PD_SLOW_CYC,
  parameter int PU_FAST_CYC = `PMC_PU_FAST_CYC,
  parameter int PU_SLOW_CYC = `PMC_PU_SLOW_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   sleep_level_wr,
  input  wire logic [`PMC_LVL_W-1:0]  sleep_level_wdata,
  input  wire logic                   sleep_trigger_wr,
  input  wire logic                   sysclk_source_select,
  input  wire logic                   low_speed_osc_select,
  input  wire logic                   fast_crystal_stable,
  input  wire logic                   port_irq,
  input  wire logic                   sleep_timer_irq,
  input  wire logic                   other_irq,
  input  wire logic                   ext_reset_req,
  input  wire logic [IO_W-1:0]        io_dir_in,
  input  wire logic [IO_W-1:0]        io_out_in,
  output logic [`PMC_LVL_W-1:0]       sleep_level_q,
  output logic                        sleep_trigger_bit_q,
  output pmc_pkg::pmc_state_type      state_q,
  output logic                        cpu_clk_en_q,
  output logic                        core_reg_on_q,
  output logic                        fast_crystal_en_q,
  output logic                        fast_rc_en_q,
  output logic                        slow_rc_en_q,
  output logic                        crystal32k_en_q,
  output logic                        sysclk_on_crystal_q,
  output logic                        port_irq_gated_q,
  output logic                        sleep_timer_irq_gated_q,
  output logic                        usb_state_clear_q,
  output logic                        resume_q,
  output logic                        restart_program_q,
  output logic [IO_W-1:0]             io_dir_q,
  output logic [IO_W-1:0]             io_out_q
);
  import pmc_pkg::*;

  localparam int CNT_W = `PMC_CNT_W;

  generate
    if (PD_FAST_CYC < 1 || PD_SLOW_CYC < 1 || PU_FAST_CYC < 1 || PU_SLOW_CYC < 1 ||
        PD_FAST_CYC >= (1 << CNT_W) || PD_SLOW_CYC >= (1 << CNT_W) ||
        PU_FAST_CYC >= (1 << CNT_W) || PU_SLOW_CYC >= (1 << CNT_W)) begin : g_chk
      $error("pmc_ctrl: sequence counts out of range");
    end
  endgenerate

  // true when a level is one of the three sleep states
  function automatic logic is_sleep_level(input logic [`PMC_LVL_W-1:0] lvl);
    is_sleep_level = (lvl != `PMC_LVL_RUN_IDLE);
  endfunction

  // true for the states with the regulator off
  function automatic logic is_slow_level(input logic [`PMC_LVL_W-1:0] lvl);
    is_slow_level = (lvl == `PMC_LVL_DEEP_TIMER) || (lvl == `PMC_LVL_DEEPEST);
  endfunction

  pmc_state_type             state_d;
  logic [`PMC_LVL_W-1:0]     target_q;
  logic                      xosc_saved_q;
  logic                      hsrc_saved_q;
  logic                      irq_open;
  logic                      any_irq;
  logic                      wake_ev;
  logic                      rst_wake;
  logic                      trig_go;
  logic                      enter_sleep;
  logic                      seq_load;
  logic [CNT_W-1:0]          seq_val;
  logic                      seq_done;
  logic                      asleep;

  // port and sleep timer interrupts pass only with level zero, other_irq always
  assign irq_open = !is_sleep_level(sleep_level_q);
  assign any_irq  = other_irq | ((port_irq | sleep_timer_irq) & irq_open);

  // trigger only acts from active
  assign trig_go = sleep_trigger_wr && (state_q == ST_ACTIVE);

  assign asleep = (state_q == ST_LIGHT) || (state_q == ST_DEEP) || (state_q == ST_DEEPEST);

  // deepest ignores the sleep timer
  always_comb begin
    wake_ev = 1'b0;
    case (state_q)
      ST_LIGHT:   wake_ev = port_irq | sleep_timer_irq;
      ST_DEEP:    wake_ev = port_irq | sleep_timer_irq;
      ST_DEEPEST: wake_ev = port_irq;
      default:    wake_ev = 1'b0;
    endcase
  end

  // external reset while asleep restarts the program
  assign rst_wake = ext_reset_req && (asleep || state_q == ST_PD || state_q == ST_IDLE);

  assign enter_sleep = (state_q == ST_PD) && seq_done;

  // next state of the mode sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: begin
        if (trig_go && !any_irq) begin
          if (is_sleep_level(sleep_level_q)) begin
            state_d = ST_PD;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (any_irq || ext_reset_req) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_PD: begin
        if (any_irq) begin
          state_d = ST_ACTIVE;
        end else if (rst_wake) begin
          state_d = ST_ACTIVE;
        end else if (seq_done) begin
          case (target_q)
            `PMC_LVL_LIGHT:      state_d = ST_LIGHT;
            `PMC_LVL_DEEP_TIMER: state_d = ST_DEEP;
            `PMC_LVL_DEEPEST:    state_d = ST_DEEPEST;
            default:             state_d = ST_ACTIVE;
          endcase
        end
      end
      ST_LIGHT, ST_DEEP, ST_DEEPEST: begin
        if (wake_ev || rst_wake) begin
          state_d = ST_PU;
        end
      end
      ST_PU: begin
        if (seq_done) begin
          state_d = ST_ACTIVE;
        end
      end
      default: state_d = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // chosen level kept through the sequence
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      target_q <= `PMC_LVL_RESET;
    end else if (trig_go) begin
      target_q <= sleep_level_q;
    end
  end

  // level field: software write wins over hardware clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sleep_level_q <= `PMC_LVL_RESET;
    end else if (sleep_level_wr) begin
      sleep_level_q <= sleep_level_wdata;
    end else if (enter_sleep) begin
      sleep_level_q <= `PMC_LVL_RUN_IDLE;
    end else if (asleep && (wake_ev || rst_wake)) begin
      sleep_level_q <= `PMC_LVL_RUN_IDLE;
    end
  end

  // trigger bit reads zero always
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sleep_trigger_bit_q <= 1'b0;
    end else begin
      sleep_trigger_bit_q <= 1'b0;
    end
  end

  // sequence lengths: light is fast, deep and deepest share slow
  always_comb begin
    seq_load = 1'b0;
    seq_val  = '0;
    if (trig_go && is_sleep_level(sleep_level_q)) begin
      seq_load = 1'b1;
      if (is_slow_level(sleep_level_q)) begin
        seq_val = CNT_W'(PD_SLOW_CYC);
      end else begin
        seq_val = CNT_W'(PD_FAST_CYC);
      end
    end else if (asleep && (wake_ev || rst_wake)) begin
      seq_load = 1'b1;
      if (state_q == ST_LIGHT) begin
        seq_val = CNT_W'(PU_FAST_CYC);
      end else begin
        seq_val = CNT_W'(PU_SLOW_CYC);
      end
    end
  end

  pmc_seq_timer #(
    .CNT_W (CNT_W)
  ) u_seq (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .load     (seq_load),
    .load_val (seq_val),
    .done_q   (seq_done)
  );

  // fast oscillators running at entry, restarted on wake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      xosc_saved_q <= 1'b0;
      hsrc_saved_q <= 1'b1;
    end else if (trig_go) begin
      xosc_saved_q <= fast_crystal_en_q;
      hsrc_saved_q <= fast_rc_en_q;
    end
  end

  // fast oscillator enables
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fast_crystal_en_q <= 1'b0;
      fast_rc_en_q      <= 1'b1;
    end else begin
      case (state_d)
        ST_ACTIVE, ST_IDLE: begin
          fast_crystal_en_q <= (sysclk_source_select == `PMC_SRC_CRYSTAL);
          fast_rc_en_q      <= (sysclk_source_select != `PMC_SRC_CRYSTAL) || !fast_crystal_stable;
        end
        ST_PD: begin
          fast_crystal_en_q <= fast_crystal_en_q;
          fast_rc_en_q      <= fast_rc_en_q;
        end
        ST_PU: begin
          fast_crystal_en_q <= xosc_saved_q;
          fast_rc_en_q      <= 1'b1;
        end
        default: begin
          fast_crystal_en_q <= 1'b0;
          fast_rc_en_q      <= 1'b0;
        end
      endcase
    end
  end

  // low-speed oscillator, off only in deepest
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slow_rc_en_q    <= 1'b1;
      crystal32k_en_q <= 1'b0;
    end else if (state_d == ST_DEEPEST) begin
      slow_rc_en_q    <= 1'b0;
      crystal32k_en_q <= 1'b0;
    end else begin
      slow_rc_en_q    <= (low_speed_osc_select == `PMC_LSO_SLOW_RC);
      crystal32k_en_q <= (low_speed_osc_select != `PMC_LSO_SLOW_RC);
    end
  end

  // system clock from crystal only once stable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sysclk_on_crystal_q <= 1'b0;
    end else begin
      sysclk_on_crystal_q <= (state_d == ST_ACTIVE || state_d == ST_IDLE) &&
                             (sysclk_source_select == `PMC_SRC_CRYSTAL) && fast_crystal_stable;
    end
  end

  // regulator off in deep and deepest
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_reg_on_q <= 1'b1;
    end else begin
      core_reg_on_q <= !(state_d == ST_DEEP || state_d == ST_DEEPEST);
    end
  end

  // cpu clock runs in active only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpu_clk_en_q <= 1'b1;
    end else begin
      cpu_clk_en_q <= (state_d == ST_ACTIVE);
    end
  end

  // gated interrupts seen by the cpu
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_irq_gated_q        <= 1'b0;
      sleep_timer_irq_gated_q <= 1'b0;
    end else begin
      port_irq_gated_q        <= port_irq & irq_open;
      sleep_timer_irq_gated_q <= sleep_timer_irq & irq_open & (state_q != ST_DEEPEST);
    end
  end

  // usb state discarded on deep and deepest entry
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      usb_state_clear_q <= 1'b0;
    end else begin
      usb_state_clear_q <= enter_sleep && is_slow_level(target_q);
    end
  end

  // resume after irq wake, restart after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      resume_q          <= 1'b0;
      restart_program_q <= 1'b1;
    end else begin
      resume_q          <= (state_q != ST_ACTIVE) && (state_d == ST_ACTIVE) && !ext_reset_req;
      restart_program_q <= ext_reset_req && (state_q != ST_ACTIVE);
    end
  end

  // pins frozen while asleep
  pmc_io_hold #(
    .IO_W (IO_W)
  ) u_hold (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .hold      (asleep || state_q == ST_PU),
    .io_dir_in (io_dir_in),
    .io_out_in (io_out_in),
    .io_dir_q  (io_dir_q),
    .io_out_q  (io_out_q)
  );
endmodule

// File: verification/pmc_osc_model.sv
// crystal oscillator model: stable flag after a start-up count
`timescale 1ns/1ps
module pmc_osc_model #(
  parameter int XTAL_CYC = 10
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic fast_crystal_en_q,
  output logic      fast_crystal_stable
);
  logic [7:0] cnt_q;

  // stable only after running a while, drops at once when stopped
  always_ff @(posedge clk_sys) begin
    if (reset || !fast_crystal_en_q) begin
      cnt_q               <= 8'h00;
      fast_crystal_stable <= 1'b0;
    end else if (cnt_q == 8'(XTAL_CYC)) begin
      fast_crystal_stable <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// File: verification/pmc_ctrl_properties.sv
// assertions on the power mode controller ports
`timescale 1ns/1ps
module pmc_ctrl_properties
  import pmc_pkg::*;
#(
  parameter int IO_W = 8
) (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   port_irq,
  input wire logic                   sleep_timer_irq,
  input wire logic                   other_irq,
  input wire logic                   ext_reset_req,
  input wire logic                   fast_crystal_stable,
  input wire logic [1:0]             sleep_level_q,
  input wire logic                   sleep_trigger_bit_q,
  input wire pmc_pkg::pmc_state_type state_q,
  input wire logic                   cpu_clk_en_q,
  input wire logic                   core_reg_on_q,
  input wire logic                   fast_crystal_en_q,
  input wire logic                   fast_rc_en_q,
  input wire logic                   slow_rc_en_q,
  input wire logic                   crystal32k_en_q,
  input wire logic                   sysclk_on_crystal_q,
  input wire logic                   port_irq_gated_q,
  input wire logic                   sleep_timer_irq_gated_q,
  input wire logic [IO_W-1:0]        io_dir_q,
  input wire logic [IO_W-1:0]        io_out_q
);
  import pmc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic asleep;
  assign asleep = state_q inside {ST_LIGHT, ST_DEEP, ST_DEEPEST};

  sequence s_wake_start;
    asleep && port_irq;
  endsequence
  sequence s_power_up;
    state_q == ST_PU ##[1:60] state_q == ST_ACTIVE;
  endsequence

  a_port_wake_up: assert property (s_wake_start |=> s_power_up)
    else $error("port wake did not reach active");
  a_trigger_reads_zero: assert property (sleep_trigger_bit_q == 1'b0)
    else $error("trigger bit read as one");
  a_active_clocks_on: assert property (state_q == ST_ACTIVE |-> cpu_clk_en_q && core_reg_on_q
    && (fast_rc_en_q || fast_crystal_en_q) && (slow_rc_en_q || crystal32k_en_q)) else $error("active resources off");
  a_idle_gates_cpu: assert property (state_q == ST_IDLE |-> !cpu_clk_en_q && core_reg_on_q
    && (fast_rc_en_q || fast_crystal_en_q)) else $error("idle gating wrong");
  a_light_fast_off: assert property (state_q == ST_LIGHT |-> !fast_crystal_en_q && !fast_rc_en_q
    && core_reg_on_q && (slow_rc_en_q || crystal32k_en_q)) else $error("light sleep resources wrong");
  a_deep_regulator_off: assert property (state_q == ST_DEEP |-> !core_reg_on_q && !fast_rc_en_q
    && !fast_crystal_en_q && (slow_rc_en_q || crystal32k_en_q)) else $error("deep sleep resources wrong");
  a_deepest_all_off: assert property (state_q == ST_DEEPEST |-> !core_reg_on_q && !fast_rc_en_q
    && !fast_crystal_en_q && !slow_rc_en_q && !crystal32k_en_q) else $error("deepest sleep resources wrong");
  a_level_blocks_irq: assert property (sleep_level_q != 2'h0 && $past(sleep_level_q) != 2'h0
    |-> !port_irq_gated_q && !sleep_timer_irq_gated_q) else $error("irq passed with level set");
  a_entry_clears_level: assert property (asleep |-> sleep_level_q == 2'h0)
    else $error("level not cleared in sleep");
  a_deepest_ignores_timer: assert property (state_q == ST_DEEPEST && sleep_timer_irq && !port_irq
    && !other_irq && !ext_reset_req |=> state_q == ST_DEEPEST) else $error("timer woke deepest sleep");
  a_sleep_io_frozen: assert property (asleep && $past(asleep) |-> $stable(io_dir_q) && $stable(io_out_q))
    else $error("pins changed in sleep");
  a_idle_irq_wakes: assert property (state_q == ST_IDLE && (other_irq || port_irq || sleep_timer_irq)
    |=> state_q == ST_ACTIVE) else $error("idle not ended by irq");
  a_crystal_not_early: assert property (!fast_crystal_stable && $past(!fast_crystal_stable)
    |-> !sysclk_on_crystal_q) else $error("clock on unstable crystal");
endmodule

bind pmc_ctrl pmc_ctrl_properties #(.IO_W(IO_W)) u_pmc_ctrl_properties (
  .clk_sys(clk_sys), .reset(reset), .port_irq(port_irq), .sleep_timer_irq(sleep_timer_irq),
  .other_irq(other_irq), .ext_reset_req(ext_reset_req), .fast_crystal_stable(fast_crystal_stable),
  .sleep_level_q(sleep_level_q), .sleep_trigger_bit_q(sleep_trigger_bit_q), .state_q(state_q),
  .cpu_clk_en_q(cpu_clk_en_q), .core_reg_on_q(core_reg_on_q), .fast_crystal_en_q(fast_crystal_en_q),
  .fast_rc_en_q(fast_rc_en_q), .slow_rc_en_q(slow_rc_en_q), .crystal32k_en_q(crystal32k_en_q),
  .sysclk_on_crystal_q(sysclk_on_crystal_q), .port_irq_gated_q(port_irq_gated_q),
  .sleep_timer_irq_gated_q(sleep_timer_irq_gated_q), .io_dir_q(io_dir_q), .io_out_q(io_out_q));

// File: verification/pmc_ctrl_tb.sv
// self-checking bench of the power mode controller
`timescale 1ns/1ps
module pmc_ctrl_tb;
  import pmc_pkg::*;
  logic clk_sys, reset, sleep_level_wr, sleep_trigger_wr, sysclk_source_select, low_speed_osc_select;
  logic fast_crystal_stable, port_irq, sleep_timer_irq, other_irq, ext_reset_req;
  logic [1:0] sleep_level_wdata, sleep_level_q;
  logic [7:0] io_dir_in, io_out_in, io_dir_q, io_out_q;
  logic sleep_trigger_bit_q, cpu_clk_en_q, core_reg_on_q, fast_crystal_en_q, fast_rc_en_q, slow_rc_en_q;
  logic crystal32k_en_q, sysclk_on_crystal_q, port_irq_gated_q, sleep_timer_irq_gated_q;
  logic usb_state_clear_q, resume_q, restart_program_q;
  pmc_state_type state_q;
  int comparisons, miscompares, n_res, n_usb, n_rst;

  pmc_ctrl u_pmc_ctrl (.clk_sys(clk_sys), .reset(reset), .sleep_level_wr(sleep_level_wr),
    .sleep_level_wdata(sleep_level_wdata), .sleep_trigger_wr(sleep_trigger_wr),
    .sysclk_source_select(sysclk_source_select), .low_speed_osc_select(low_speed_osc_select),
    .fast_crystal_stable(fast_crystal_stable), .port_irq(port_irq), .sleep_timer_irq(sleep_timer_irq),
    .other_irq(other_irq), .ext_reset_req(ext_reset_req), .io_dir_in(io_dir_in), .io_out_in(io_out_in),
    .sleep_level_q(sleep_level_q), .sleep_trigger_bit_q(sleep_trigger_bit_q), .state_q(state_q),
    .cpu_clk_en_q(cpu_clk_en_q), .core_reg_on_q(core_reg_on_q), .fast_crystal_en_q(fast_crystal_en_q),
    .fast_rc_en_q(fast_rc_en_q), .slow_rc_en_q(slow_rc_en_q), .crystal32k_en_q(crystal32k_en_q),
    .sysclk_on_crystal_q(sysclk_on_crystal_q), .port_irq_gated_q(port_irq_gated_q),
    .sleep_timer_irq_gated_q(sleep_timer_irq_gated_q), .usb_state_clear_q(usb_state_clear_q),
    .resume_q(resume_q), .restart_program_q(restart_program_q), .io_dir_q(io_dir_q), .io_out_q(io_out_q));
  pmc_osc_model u_pmc_osc_model (.clk_sys(clk_sys), .reset(reset), .fast_crystal_en_q(fast_crystal_en_q),
    .fast_crystal_stable(fast_crystal_stable));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // count the cycles in which each pulse output is high
  always @(negedge clk_sys) begin
    n_res += int'(resume_q === 1'b1);
    n_usb += int'(usb_state_clear_q === 1'b1);
    n_rst += int'(restart_program_q === 1'b1);
  end

  task finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wait_st(input pmc_state_type s);
    for (int i = 0; i < 200 && state_q !== s; i++) @(negedge clk_sys);
    chk("state", state_q, s);
    if (state_q !== s) finish_test;
  endtask
  task wait_xtal;
    for (int i = 0; i < 200 && sysclk_on_crystal_q !== 1'b1; i++) @(negedge clk_sys);
    chk("on_crystal", sysclk_on_crystal_q, 8'h01);
  endtask
  // level write, three idle cycles, then trigger
  task go(input logic [1:0] lvl);
    sleep_level_wdata = lvl;
    sleep_level_wr = 1'b1;
    @(negedge clk_sys);
    sleep_level_wr = 1'b0;
    repeat (3) @(negedge clk_sys);
    if (sleep_level_q !== 2'h0 || lvl == 2'h0) begin
      sleep_trigger_wr = 1'b1;
      @(negedge clk_sys);
      sleep_trigger_wr = 1'b0;
    end
  endtask
  task t_idle;
    go(2'h0);
    wait_st(ST_IDLE);
    chk("cpu_idle", cpu_clk_en_q, 8'h00);
    chk("trigger", sleep_trigger_bit_q, 8'h00);
    other_irq = 1'b1;
    wait_st(ST_ACTIVE);
    other_irq = 1'b0;
    chk("cpu_run", cpu_clk_en_q, 8'h01);
  endtask
  task t_block;
    sleep_level_wdata = 2'h1;
    sleep_level_wr = 1'b1;
    @(negedge clk_sys);
    sleep_level_wr = 1'b0;
    port_irq = 1'b1;
    sleep_timer_irq = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("gated_blocked", port_irq_gated_q, 8'h00);
    chk("timer_blocked", sleep_timer_irq_gated_q, 8'h00);
    go(2'h0); // handler clears level
    chk("gated_open", port_irq_gated_q, 8'h01);
    chk("timer_open", sleep_timer_irq_gated_q, 8'h01);
    port_irq = 1'b0;
    sleep_timer_irq = 1'b0;
    wait_st(ST_ACTIVE);
  endtask
  // other irq during power down returns to active, level kept
  task t_abort;
    go(2'h2);
    chk("pd", state_q, ST_PD);
    other_irq = 1'b1;
    @(negedge clk_sys);
    other_irq = 1'b0;
    chk("abort", state_q, ST_ACTIVE);
    chk("abort_level", sleep_level_q, 8'h02);
    sleep_level_wdata = 2'h0;
    sleep_level_wr = 1'b1;
    @(negedge clk_sys);
    sleep_level_wr = 1'b0;
    chk("isr_clear", sleep_level_q, 8'h00);
  endtask
  // src 0 port, 1 sleep timer, 2 external reset
  task t_sleep(input logic [1:0] lvl, input pmc_state_type st, input int src);
    int r, u, x;
    repeat (40) @(negedge clk_sys);
    r = n_res;
    u = n_usb;
    x = n_rst;
    io_dir_in = 8'hA5;
    io_out_in = 8'h3C;
    go(lvl);
    wait_st(st);
    chk("level_clr", sleep_level_q, 8'h00);
    io_dir_in = 8'h5A;
    io_out_in = 8'hC3;
    repeat (3) @(negedge clk_sys);
    chk("dir_hold", io_dir_q, 8'hA5);
    chk("out_hold", io_out_q, 8'h3C);
    if (st == ST_DEEPEST) begin
      sleep_timer_irq = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk("no_timer_wake", state_q, ST_DEEPEST);
    end
    port_irq = (src == 0);
    sleep_timer_irq = (src == 1);
    ext_reset_req = (src == 2);
    wait_st(ST_ACTIVE);
    port_irq = 1'b0;
    sleep_timer_irq = 1'b0;
    ext_reset_req = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("level_wake", sleep_level_q, 8'h00);
    chk("dir_follow", io_dir_q, 8'h5A);
    chk("out_follow", io_out_q, 8'hC3);
    chk("usb_clear", n_usb != u, lvl > 2'h1);
    chk("resume", n_res - r, src < 2);
    chk("restart", n_rst != x, src == 2);
  endtask

  initial begin
    reset = 1'b1;
    {sleep_level_wr, sleep_trigger_wr, port_irq, sleep_timer_irq, other_irq, ext_reset_req} = 6'h00;
    sleep_level_wdata = 2'h0;
    sysclk_source_select = 1'b1;
    low_speed_osc_select = 1'b1;
    io_dir_in = 8'h00;
    io_out_in = 8'h00;
    repeat (3) @(negedge clk_sys);
    chk("restart_rst", restart_program_q, 8'h01);
    reset = 1'b0;
    @(negedge clk_sys);
    chk("state_rst", state_q, ST_ACTIVE);
    chk("core_on", core_reg_on_q, 8'h01);
    chk("level_rst", sleep_level_q, 8'h00);
    t_idle;
    t_block;
    t_abort;
    t_sleep(2'h1, ST_LIGHT, 0);
    t_sleep(2'h2, ST_DEEP, 1);
    t_sleep(2'h3, ST_DEEPEST, 0);
    t_sleep(2'h1, ST_LIGHT, 1);
    t_sleep(2'h2, ST_DEEP, 2);
    sysclk_source_select = 1'b0;
    low_speed_osc_select = 1'b0;
    wait_xtal; // crystal stable before sleeping
    t_sleep(2'h1, ST_LIGHT, 0);
    wait_xtal;
    chk("osc32k_on", crystal32k_en_q, 8'h01);
    chk("slow_rc_off", slow_rc_en_q, 8'h00);
    finish_test;
  end
endmodule
